// File: rtl/mas_slice.sv
// multiply-add slice with pattern detector and cascade ports
`timescale 1ns/1ns
`default_nettype none
module mas_slice
  import mas_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [AW-1:0] a_i,
  input wire logic [AW-1:0] acin_i,
  input wire logic [BW-1:0] b_i,
  input wire logic [BW-1:0] bcin_i,
  input wire logic [PW-1:0] c_i,
  input wire logic [PW-1:0] pcin_i,
  input wire logic carrycascin_i,
  input wire logic multsigncascin_i,
  input wire logic [OPW-1:0] opmode_i,
  input wire logic [ALW-1:0] alumode_i,
  input wire logic carryin_i,
  input wire logic [CSW-1:0] carryinsel_i,
  input wire logic [CWW-1:0] ctrl_word_i,
  input wire logic ctrl_word_sel_i,
  input wire logic acin_sel_i,
  input wire logic bcin_sel_i,
  input wire logic has_c_i,
  input wire mas_split_t split_i,
  input wire logic pat_from_c_i,
  input wire logic mask_from_c_i,
  input wire mas_rnd_t rnd_sel_i,
  input wire logic [PW-1:0] pattern_cfg_i,
  input wire logic [PW-1:0] mask_cfg_i,
  input wire logic autoreset_i,
  input wire logic use_a_reg_i,
  input wire logic use_b_reg_i,
  input wire logic use_c_reg_i,
  input wire logic use_m_reg_i,
  input wire logic use_opm_reg_i,
  input wire logic use_alu_reg_i,
  input wire logic use_cin_reg_i,
  input wire logic use_csel_reg_i,
  input wire logic rst_a_i,
  input wire logic rst_b_i,
  input wire logic rst_c_i,
  input wire logic rst_m_i,
  input wire logic rst_p_i,
  input wire logic rst_cin_i,
  input wire logic rst_alu_i,
  input wire logic rst_ctrl_i,
  input wire logic ce_a_i,
  input wire logic ce_b_i,
  input wire logic ce_c_i,
  input wire logic ce_m_i,
  input wire logic ce_p_i,
  input wire logic ce_cin_i,
  input wire logic ce_alu_i,
  input wire logic ce_ctrl_i,
  input wire logic grst_on_i,
  input wire logic rst_i,
  input wire logic gen_on_i,
  input wire logic en_i,
  output logic [PW-1:0] p_o,
  output logic [PW-1:0] pcout_o,
  output logic [AW-1:0] acout_o,
  output logic [BW-1:0] bcout_o,
  output logic [NSEC-1:0] carryout_o,
  output logic carrycascout_o,
  output logic multsigncascout_o,
  output logic pattern_o,
  output logic patternb_o,
  output logic overflow_o,
  output logic underflow_o
);
  // ***************************************************
  // stage reset and enable steering
  // ***************************************************
  function automatic logic eff_rst(input logic r, input logic gon, input logic g);
    return r | (gon & g);
  endfunction : eff_rst

  function automatic logic eff_ce(input logic c, input logic gon, input logic g);
    return gon ? g : c;
  endfunction : eff_ce

  // split points break the carry chain between 12-bit sections
  function automatic logic brk_at(input mas_split_t s, input int k);
    return (s == MAS_FOUR12) || ((s == MAS_TWO24) && (k == NSEC / 2));
  endfunction : brk_at

  logic p_rst;
  logic p_ce;
  logic [AW-1:0] a_op;
  logic [BW-1:0] b_op;
  logic [PW-1:0] c_raw;
  logic [PW-1:0] c_op;
  logic signed [MW-1:0] m_raw;
  logic [MW-1:0] m_op;
  logic [OPW-1:0] opm_raw;
  logic [OPW-1:0] opm;
  logic [ALW-1:0] alu_raw;
  logic [ALW-1:0] alu_op;
  logic cin_raw;
  logic cin_op;
  logic [CSW-1:0] csel_raw;
  logic [CSW-1:0] csel;
  logic [PW-1:0] m_ext;
  logic [PW-1:0] x_val;
  logic [PW-1:0] y_val;
  logic [PW-1:0] z_val;
  logic cin_val;
  logic [PW-1:0] s_xy;
  logic [PW-1:0] z_in;
  logic [PW-1:0] r_sum;
  logic [NSEC-1:0] co;
  logic [NSEC-1:0] ci;
  logic [PW-1:0] alu;
  logic [NSEC-1:0] next_carry;
  logic [PW-1:0] pat;
  logic [PW-1:0] mask;
  logic match;
  logic matchb;
  logic [PW-1:0] p;

  assign p_rst = eff_rst(rst_p_i, grst_on_i, rst_i);
  assign p_ce = eff_ce(ce_p_i, gen_on_i, en_i);

  // ***************************************************
  // operand and control stages
  // ***************************************************
  // cascade inputs only ever come from a twin slice, so no retiming here
  mas_preg #(.W(AW)) u_a (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .rst_i(eff_rst(rst_a_i, grst_on_i, rst_i)), .ce_i(eff_ce(ce_a_i, gen_on_i, en_i)),
    .use_i(use_a_reg_i), .d_i(acin_sel_i ? acin_i : a_i), .q_o(acout_o), .y_o(a_op));
  mas_preg #(.W(BW)) u_b (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .rst_i(eff_rst(rst_b_i, grst_on_i, rst_i)), .ce_i(eff_ce(ce_b_i, gen_on_i, en_i)),
    .use_i(use_b_reg_i), .d_i(bcin_sel_i ? bcin_i : b_i), .q_o(bcout_o), .y_o(b_op));

  // an absent C port reads as zero
  assign c_raw = has_c_i ? c_i : '0;
  mas_preg #(.W(PW)) u_c (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .rst_i(eff_rst(rst_c_i, grst_on_i, rst_i)), .ce_i(eff_ce(ce_c_i, gen_on_i, en_i)),
    .use_i(use_c_reg_i), .d_i(c_raw), .q_o(), .y_o(c_op));

  // signed product, optionally registered
  assign m_raw = $signed(a_op) * $signed(b_op);
  mas_preg #(.W(MW)) u_m (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .rst_i(eff_rst(rst_m_i, grst_on_i, rst_i)), .ce_i(eff_ce(ce_m_i, gen_on_i, en_i)),
    .use_i(use_m_reg_i), .d_i(m_raw), .q_o(), .y_o(m_op));

  // control fields from the packed word or from separate ports
  assign opm_raw = ctrl_word_sel_i ? ctrl_word_i[OPM_LSB +: OPW] : opmode_i;
  assign alu_raw = ctrl_word_sel_i ? ctrl_word_i[ALU_LSB +: ALW] : alumode_i;
  assign cin_raw = ctrl_word_sel_i ? ctrl_word_i[CIN_BIT] : carryin_i;
  assign csel_raw = ctrl_word_sel_i ? ctrl_word_i[CSEL_LSB +: CSW] : carryinsel_i;

  // operation and carry-select share the control reset and enable
  mas_preg #(.W(OPW)) u_opm (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .rst_i(eff_rst(rst_ctrl_i, grst_on_i, rst_i)), .ce_i(eff_ce(ce_ctrl_i, gen_on_i, en_i)),
    .use_i(use_opm_reg_i), .d_i(opm_raw), .q_o(), .y_o(opm));
  mas_preg #(.W(CSW)) u_csel (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .rst_i(eff_rst(rst_ctrl_i, grst_on_i, rst_i)), .ce_i(eff_ce(ce_ctrl_i, gen_on_i, en_i)),
    .use_i(use_csel_reg_i), .d_i(csel_raw), .q_o(), .y_o(csel));
  mas_preg #(.W(ALW)) u_alu (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .rst_i(eff_rst(rst_alu_i, grst_on_i, rst_i)), .ce_i(eff_ce(ce_alu_i, gen_on_i, en_i)),
    .use_i(use_alu_reg_i), .d_i(alu_raw), .q_o(), .y_o(alu_op));
  mas_preg #(.W(1)) u_cin (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .rst_i(eff_rst(rst_cin_i, grst_on_i, rst_i)), .ce_i(eff_ce(ce_cin_i, gen_on_i, en_i)),
    .use_i(use_cin_reg_i), .d_i(cin_raw), .q_o(), .y_o(cin_op));

  // ***************************************************
  // operand multiplexers
  // ***************************************************
  assign m_ext = {{(PW - MW){m_op[MW-1]}}, m_op};

  // selects change every cycle, so operation is chosen at run time
  always_comb begin
    case (opm[X_LSB +: 2])
      X_MULT: x_val = m_ext;
      X_P: x_val = p;
      X_AB: x_val = {{(PW - MW){a_op[AW-1]}}, a_op, b_op};
      default: x_val = '0;
    endcase
    case (opm[Y_LSB +: 2])
      Y_ONES: y_val = '1;
      Y_C: y_val = c_op;
      default: y_val = '0;
    endcase
    case (opm[Z_LSB +: 3])
      Z_PCIN: z_val = pcin_i;
      Z_P: z_val = p;
      Z_C: z_val = c_op;
      Z_PCIN_SH: z_val = $signed(pcin_i) >>> CASC_SHIFT;
      Z_P_SH: z_val = $signed(p) >>> CASC_SHIFT;
      default: z_val = '0;
    endcase
    case (csel)
      CS_NOT_P: cin_val = ~p[PW-1];
      CS_CASC: cin_val = carrycascin_i;
      CS_MSIGN: cin_val = multsigncascin_i;
      default: cin_val = cin_op;
    endcase
  end

  // ***************************************************
  // sectioned adder
  // ***************************************************
  // subtract as ~(~z + w): same adder serves both, split sections stay exact
  assign s_xy = x_val + y_val;
  assign z_in = (alu_op == ALU_SUB) ? ~z_val : z_val;

  for (genvar k = 0; k < NSEC; k++) begin : g_sec
    if (k == 0) begin : g_first
      assign ci[k] = cin_val;
    end else begin : g_next
      assign ci[k] = brk_at(split_i, k) ? 1'b0 : co[k-1];
    end
    assign {co[k], r_sum[k*SECW +: SECW]} = {1'b0, z_in[k*SECW +: SECW]}
      + {1'b0, s_xy[k*SECW +: SECW]} + {{SECW{1'b0}}, ci[k]};
  end

  always_comb begin
    case (alu_op)
      ALU_SUB: alu = ~r_sum;
      ALU_XOR: alu = x_val ^ z_val;
      ALU_AND: alu = x_val & z_val;
      ALU_OR: alu = x_val | z_val;
      default: alu = r_sum;
    endcase
  end

  // carry-out bits grouped by split mode, upper bits unused read zero
  always_comb begin
    case (split_i)
      MAS_TWO24: next_carry = {2'h0, co[NSEC-1], co[NSEC/2-1]};
      MAS_FOUR12: next_carry = co;
      default: next_carry = {3'h0, co[NSEC-1]};
    endcase
  end

  // ***************************************************
  // pattern detector
  // ***************************************************
  assign pat = pat_from_c_i ? c_op : pattern_cfg_i;

  // rounding masks track C, so rounding position follows the data
  always_comb begin
    case (rnd_sel_i)
      MAS_MASK_RND1: mask = ~c_op << RND1_SH;
      MAS_MASK_RND2: mask = ~c_op << RND2_SH;
      default: mask = mask_from_c_i ? c_op : mask_cfg_i;
    endcase
  end

  // a set mask bit forces its compare term true, i.e. ignored
  assign match = &((alu ~^ pat) | mask);
  assign matchb = &((alu ~^ ~pat) | mask);

  // ***************************************************
  // output register and flags
  // ***************************************************
  // reset-on-match acts even while the enable is low, as a flush
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      p <= '0;
    end else if (p_rst) begin
      p <= '0;
    end else if (autoreset_i && pattern_o) begin
      p <= '0;
    end else if (p_ce) begin
      p <= alu;
    end
  end

  // flags share the p reset and enable; a clear on match resets p only
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pattern_o <= 1'b0;
      patternb_o <= 1'b0;
      overflow_o <= 1'b0;
      underflow_o <= 1'b0;
      carryout_o <= '0;
      carrycascout_o <= 1'b0;
      multsigncascout_o <= 1'b0;
    end else if (p_rst) begin
      pattern_o <= 1'b0;
      patternb_o <= 1'b0;
      overflow_o <= 1'b0;
      underflow_o <= 1'b0;
      carryout_o <= '0;
      carrycascout_o <= 1'b0;
      multsigncascout_o <= 1'b0;
    end else if (p_ce) begin
      pattern_o <= match;
      patternb_o <= matchb;
      overflow_o <= pattern_o & ~match & ~matchb;
      underflow_o <= patternb_o & ~match & ~matchb;
      carryout_o <= next_carry;
      carrycascout_o <= co[NSEC-1];
      multsigncascout_o <= m_op[MW-1];
    end
  end

  assign p_o = p;
  assign pcout_o = p;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  a_match_clears_p: assert property ((autoreset_i && pattern_o && !p_rst) |=> (p_o == '0))
    else $error("p not cleared after match");
  a_pat_tracks_p: assert property ((p_ce && !p_rst && !(autoreset_i && pattern_o))
    |=> (pattern_o == &((p_o ~^ $past(pat)) | $past(mask))))
    else $error("match flag disagrees with p");
  a_patb_tracks_p: assert property ((p_ce && !p_rst && !(autoreset_i && pattern_o))
    |=> (patternb_o == &((p_o ~^ ~$past(pat)) | $past(mask))))
    else $error("inverse match flag disagrees with p");
  a_p_sync_clear: assert property (p_rst |=> (p_o == '0) && (carryout_o == '0) && !pattern_o)
    else $error("p stage reset ignored");
  a_p_hold_ce: assert property ((!p_ce && !p_rst && !(autoreset_i && pattern_o)) |=> $stable(p_o))
    else $error("p moved with enable low");
  a_ovf_cause: assert property ($rose(overflow_o) |-> ($past(pattern_o) && !pattern_o && !patternb_o))
    else $error("overflow without leaving match");
  a_unf_cause: assert property ($rose(underflow_o) |-> ($past(patternb_o) && !pattern_o && !patternb_o))
    else $error("underflow without leaving inverse match");
  a_acin_select: assert property ((acin_sel_i && eff_ce(ce_a_i, gen_on_i, en_i)
    && !eff_rst(rst_a_i, grst_on_i, rst_i)) |=> (acout_o == $past(acin_i)))
    else $error("a stage did not take cascade input");
  a_bcin_select: assert property ((!bcin_sel_i && eff_ce(ce_b_i, gen_on_i, en_i)
    && !eff_rst(rst_b_i, grst_on_i, rst_i)) |=> (bcout_o == $past(b_i)))
    else $error("b stage did not take direct input");
  a_carry_width: assert property ((split_i == MAS_ONE48 && p_ce && !p_rst) |=> (carryout_o[3:1] == 3'h0))
    else $error("extra carry bits in single adder mode");

  c_auto_clear: cover property (autoreset_i && pattern_o ##1 (p_o == '0));
  c_overflow: cover property ($rose(overflow_o));
  c_underflow: cover property ($rose(underflow_o));
  c_split4: cover property (split_i == MAS_FOUR12 && carryout_o == 4'hF);
endmodule : mas_slice
`default_nettype wire

// File: rtl/mas_pkg.sv
// shared constants and types of the multiply-add slice
package mas_pkg;
  // ***************************************************
  // widths
  // ***************************************************
  localparam int AW = 25;
  localparam int BW = 18;
  localparam int MW = AW + BW;
  localparam int PW = 48;
  localparam int SECW = 12;
  localparam int NSEC = 4;
  localparam int CWW = 15;
  localparam int OPW = 7;
  localparam int ALW = 4;
  localparam int CSW = 3;
  // ***************************************************
  // consolidated control word fields
  // ***************************************************
  localparam int OPM_LSB = 0;
  localparam int ALU_LSB = 7;
  localparam int CIN_BIT = 11;
  localparam int CSEL_LSB = 12;
  // ***************************************************
  // operation mode fields and operand selects
  // ***************************************************
  localparam int X_LSB = 0;
  localparam int Y_LSB = 2;
  localparam int Z_LSB = 4;
  localparam logic [1:0] X_MULT = 2'h1;
  localparam logic [1:0] X_P = 2'h2;
  localparam logic [1:0] X_AB = 2'h3;
  localparam logic [1:0] Y_ONES = 2'h2;
  localparam logic [1:0] Y_C = 2'h3;
  localparam logic [2:0] Z_PCIN = 3'h1;
  localparam logic [2:0] Z_P = 3'h2;
  localparam logic [2:0] Z_C = 3'h3;
  localparam logic [2:0] Z_PCIN_SH = 3'h5;
  localparam logic [2:0] Z_P_SH = 3'h6;
  localparam int CASC_SHIFT = 17;
  // arithmetic and logic modes
  localparam logic [3:0] ALU_SUB = 4'h3;
  localparam logic [3:0] ALU_XOR = 4'h4;
  localparam logic [3:0] ALU_AND = 4'hC;
  localparam logic [3:0] ALU_OR = 4'hE;
  // carry-in selects
  localparam logic [2:0] CS_NOT_P = 3'h1;
  localparam logic [2:0] CS_CASC = 3'h2;
  localparam logic [2:0] CS_MSIGN = 3'h3;
  localparam int RND1_SH = 1;
  localparam int RND2_SH = 2;
  typedef enum logic [1:0] {MAS_ONE48, MAS_TWO24, MAS_FOUR12} mas_split_t;
  typedef enum logic [1:0] {MAS_MASK_CFG, MAS_MASK_RND1, MAS_MASK_RND2} mas_rnd_t;
endpackage : mas_pkg

// File: rtl/mas_preg.sv
// optional pipeline register with synchronous clear and bypass
`timescale 1ns/1ns
`default_nettype none
module mas_preg #(parameter int W = 1) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic use_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o,
  output logic [W-1:0] y_o
);
  // clear beats enable so a held stage can still be flushed
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= '0;
    end else if (rst_i) begin
      q_o <= '0;
    end else if (ce_i) begin
      q_o <= d_i;
    end
  end
  // bypass when the stage is not configured in
  assign y_o = use_i ? q_o : d_i;
endmodule : mas_preg
`default_nettype wire

// File: bench/mas_twin.sv
// behavioural neighbour slice that drives the cascade inputs
`timescale 1ns/1ns
`default_nettype none
module mas_twin
  import mas_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ld_i,
  input wire logic [AW-1:0] a_i,
  input wire logic [BW-1:0] b_i,
  input wire logic [PW-1:0] p_i,
  input wire logic cc_i,
  input wire logic ms_i,
  output logic [AW-1:0] acout_o,
  output logic [BW-1:0] bcout_o,
  output logic [PW-1:0] pcout_o,
  output logic carrycascout_o,
  output logic multsigncascout_o
);
  // ***************************************************
  // cascade outputs
  // ***************************************************
  // straight from flops like a real twin, so no combinational path into the slice
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {acout_o, bcout_o, pcout_o, carrycascout_o, multsigncascout_o} <= '0;
    end else if (ld_i) begin
      {acout_o, bcout_o, pcout_o, carrycascout_o, multsigncascout_o} <= {a_i, b_i, p_i, cc_i, ms_i};
    end
  end
endmodule : mas_twin
`default_nettype wire

// File: bench/mas_slice_tb.sv
// self-checking bench of the multiply-add slice with a scoreboard queue
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e); end end
module mas_slice_tb
  import mas_pkg::*;
;
  typedef struct {int due; logic [PW-1:0] p; logic [NSEC:0] co; logic [4:0] fl; bit chk_fl; bit co_ok;} mas_note_t;
  localparam logic [6:0] XAB_OP = {3'h0, 2'h0, X_AB};
  logic ref_clk_i, nrst_i, carryin_i, ctrl_word_sel_i, acin_sel_i, bcin_sel_i, has_c_i, pat_from_c_i, mask_from_c_i;
  logic autoreset_i, grst_on_i, rst_i, gen_on_i, en_i, tw_ld, tw_cc, tw_ms, mpat, mpatb;
  logic [AW-1:0] a_i, tw_a, acout_o;
  logic [BW-1:0] b_i, tw_b, bcout_o;
  logic [PW-1:0] c_i, pattern_cfg_i, mask_cfg_i, tw_p, mp, p_o, pcout_o;
  logic signed [PW-1:0] rv;
  logic [OPW-1:0] opmode_i;
  logic [ALW-1:0] alumode_i;
  logic [CSW-1:0] carryinsel_i;
  logic [CWW-1:0] ctrl_word_i;
  logic [7:0] use_v, rst_v, ce_v;
  logic [NSEC-1:0] carryout_o;
  logic carrycascout_o, multsigncascout_o, pattern_o, patternb_o, overflow_o, underflow_o;
  mas_split_t split_i;
  mas_rnd_t rnd_sel_i;
  wire logic [AW-1:0] acin_i;
  wire logic [BW-1:0] bcin_i;
  wire logic [PW-1:0] pcin_i;
  wire logic carrycascin_i, multsigncascin_i;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  mas_note_t notes[$];
  mas_note_t cur;
  logic [6:0] opms [6] = '{{Z_C, Y_C, X_AB}, {Z_P, Y_ONES, X_P}, {Z_P_SH, 2'h0, X_MULT}, {Z_PCIN, Y_C, X_AB},
                           {Z_PCIN_SH, 2'h0, X_AB}, 7'h00};
  logic [ALW-1:0] alus [5] = '{4'h0, ALU_SUB, ALU_XOR, ALU_AND, ALU_OR};
  logic [BW-1:0] ovs [4] = '{18'h00100, 18'h00101, 18'h001FF, 18'h00102};
  logic [7:0] rows [9] = '{8'hC1, 8'h40, 8'h02, 8'h81, 8'h40, 8'h71, 8'h40, 8'h4A, 8'h0C};

  mas_slice dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .a_i(a_i), .acin_i(acin_i), .b_i(b_i), .bcin_i(bcin_i),
    .c_i(c_i), .pcin_i(pcin_i), .carrycascin_i(carrycascin_i), .multsigncascin_i(multsigncascin_i),
    .opmode_i(opmode_i), .alumode_i(alumode_i), .carryin_i(carryin_i), .carryinsel_i(carryinsel_i),
    .ctrl_word_i(ctrl_word_i), .ctrl_word_sel_i(ctrl_word_sel_i), .acin_sel_i(acin_sel_i), .bcin_sel_i(bcin_sel_i),
    .has_c_i(has_c_i), .split_i(split_i), .pat_from_c_i(pat_from_c_i), .mask_from_c_i(mask_from_c_i),
    .rnd_sel_i(rnd_sel_i), .pattern_cfg_i(pattern_cfg_i), .mask_cfg_i(mask_cfg_i), .autoreset_i(autoreset_i),
    .use_a_reg_i(use_v[0]), .use_b_reg_i(use_v[1]), .use_c_reg_i(use_v[2]), .use_m_reg_i(use_v[3]),
    .use_opm_reg_i(use_v[4]), .use_alu_reg_i(use_v[5]), .use_cin_reg_i(use_v[6]), .use_csel_reg_i(use_v[7]),
    .rst_a_i(rst_v[0]), .rst_b_i(rst_v[1]), .rst_c_i(rst_v[2]), .rst_m_i(rst_v[3]), .rst_p_i(rst_v[4]),
    .rst_cin_i(rst_v[5]), .rst_alu_i(rst_v[6]), .rst_ctrl_i(rst_v[7]), .ce_a_i(ce_v[0]), .ce_b_i(ce_v[1]),
    .ce_c_i(ce_v[2]), .ce_m_i(ce_v[3]), .ce_p_i(ce_v[4]), .ce_cin_i(ce_v[5]), .ce_alu_i(ce_v[6]),
    .ce_ctrl_i(ce_v[7]), .grst_on_i(grst_on_i), .rst_i(rst_i), .gen_on_i(gen_on_i), .en_i(en_i), .p_o(p_o),
    .pcout_o(pcout_o), .acout_o(acout_o), .bcout_o(bcout_o), .carryout_o(carryout_o),
    .carrycascout_o(carrycascout_o), .multsigncascout_o(multsigncascout_o), .pattern_o(pattern_o),
    .patternb_o(patternb_o), .overflow_o(overflow_o), .underflow_o(underflow_o));

  // twin never resets: it is loaded once while the slice is still held in reset
  mas_twin twin (.ref_clk_i(ref_clk_i), .nrst_i(1'b1), .ld_i(tw_ld), .a_i(tw_a), .b_i(tw_b), .p_i(tw_p),
    .cc_i(tw_cc), .ms_i(tw_ms), .acout_o(acin_i), .bcout_o(bcin_i), .pcout_o(pcin_i),
    .carrycascout_o(carrycascin_i), .multsigncascout_o(multsigncascin_i));

  // ***************************************************
  // reference model of one adder pass
  // ***************************************************
  function automatic void calc(input logic [6:0] om, input logic [3:0] al, input logic ci, input logic [2:0] cs,
                               output logic [PW-1:0] r, output logic [NSEC-1:0] co);
    logic [PW-1:0] x, y, z, w, ce;
    logic signed [PW-1:0] sa, sb;
    logic cin, cy;
    int sw;
    ce = has_c_i ? c_i : '0;
    sa = $signed(acin_sel_i ? tw_a : a_i);
    sb = $signed(bcin_sel_i ? tw_b : b_i);
    x = om[1:0] == X_MULT ? sa * sb : om[1:0] == X_P ? mp : '0;
    if (om[1:0] == X_AB) begin
      sa = $signed({acin_sel_i ? tw_a : a_i, bcin_sel_i ? tw_b : b_i});
      x = sa;
    end
    y = om[3:2] == Y_ONES ? '1 : om[3:2] == Y_C ? ce : '0;
    case (om[6:4])
      Z_PCIN: z = tw_p;
      Z_P: z = mp;
      Z_C: z = ce;
      Z_PCIN_SH: z = $signed(tw_p) >>> CASC_SHIFT;
      Z_P_SH: z = $signed(mp) >>> CASC_SHIFT;
      default: z = '0;
    endcase
    cin = cs == CS_NOT_P ? ~mp[PW-1] : cs == CS_CASC ? tw_cc : cs == CS_MSIGN ? tw_ms : ci;
    w = x + y + PW'(cin);
    // sections ripple on their own so carries never leak across a split boundary
    sw = split_i == MAS_TWO24 ? 2 * SECW : split_i == MAS_FOUR12 ? SECW : PW;
    co = '0;
    cy = 1'b0;
    for (int j = 0; j < PW; j++) begin
      if (j % sw == 0) cy = 1'b0;
      {cy, r[j]} = z[j] + w[j] + cy;
      if (j % sw == sw - 1) co[j / sw] = cy;
    end
    case (al)
      ALU_SUB: r = z - w;
      ALU_XOR: r = x ^ z;
      ALU_AND: r = x & z;
      ALU_OR: r = x | z;
      default: ;
    endcase
  endfunction : calc

  // drive one operation and note its result; k: 0 value, 1 cleared, 2 held
  task automatic issue(input logic [6:0] om, input logic [3:0] al, input logic ci, input logic [2:0] cs,
                       input int lat, input int k, input bit cw);
    logic [PW-1:0] r, m, pt, ce;
    logic [NSEC-1:0] co;
    logic hit, hitb;
    logic signed [MW-1:0] pr;
    mas_note_t n;
    ctrl_word_sel_i = cw;
    ctrl_word_i = {cs, ci, al, om};
    {opmode_i, alumode_i, carryin_i, carryinsel_i} = cw ? ~{om, al, ci, cs} : {om, al, ci, cs};
    calc(om, al, ci, cs, r, co);
    // the product sign leaves on the sign cascade with the result it belongs to
    pr = $signed(acin_sel_i ? tw_a : a_i) * $signed(bcin_sel_i ? tw_b : b_i);
    ce = has_c_i ? c_i : '0;
    m = rnd_sel_i == MAS_MASK_RND1 ? ~ce << RND1_SH : rnd_sel_i == MAS_MASK_RND2 ? ~ce << RND2_SH :
        mask_from_c_i ? ce : mask_cfg_i;
    pt = pat_from_c_i ? ce : pattern_cfg_i;
    hit = ((r ^ pt) & ~m) == '0;
    hitb = ((r ^ ~pt) & ~m) == '0;
    n = '{cyc + lat, k == 1 ? '0 : k == 2 ? mp : r,
          {co[split_i == MAS_FOUR12 ? NSEC - 1 : split_i == MAS_TWO24 ? 1 : 0], co},
          {pr[MW-1], hit, hitb, mpat & !hit & !hitb, mpatb & !hit & !hitb},
          k == 0, k == 0 && !(al inside {ALU_SUB, ALU_XOR, ALU_AND, ALU_OR})};
    notes.push_back(n);
    if (k == 0) {mpat, mpatb} = {hit, hitb};
    mp = n.p;
    @(posedge ref_clk_i);
    #1;
  endtask : issue

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // ***************************************************
  // clock, cycle count and result watcher
  // ***************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) cyc <= cyc + 1;

  // results are sampled mid-cycle, well clear of the launching edge
  always @(negedge ref_clk_i) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      cur = notes.pop_front();
      `CHK(p_o, cur.p, "result")
      `CHK(pcout_o, cur.p, "cascade result")
      if (cur.chk_fl) `CHK({pattern_o, patternb_o}, cur.fl[3:2], "match flags")
      if (cur.chk_fl) `CHK({overflow_o, underflow_o}, cur.fl[1:0], "range flags")
      if (cur.chk_fl) `CHK(multsigncascout_o, cur.fl[4], "sign cascade")
      if (cur.co_ok) `CHK(carryout_o, cur.co[NSEC-1:0], "carry")
      if (cur.co_ok) `CHK(carrycascout_o, cur.co[NSEC], "carry cascade")
    end
  end

  initial begin
    repeat (2000) @(posedge ref_clk_i);
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    conclude();
  end

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    void'($urandom(32'h8A2C9A8E));
    {a_i, b_i, c_i, pattern_cfg_i, opmode_i, alumode_i, carryin_i, carryinsel_i, ctrl_word_i} = '0;
    {ctrl_word_sel_i, acin_sel_i, bcin_sel_i, pat_from_c_i, mask_from_c_i, autoreset_i, rst_v} = '0;
    {grst_on_i, rst_i, gen_on_i, en_i, mp, mpat, mpatb} = '0;
    {mask_cfg_i, use_v, ce_v} = '1;
    has_c_i = 1'b1;
    split_i = MAS_ONE48;
    rnd_sel_i = MAS_MASK_CFG;
    {tw_a, tw_b, tw_p} = {AW'($urandom), BW'($urandom), $urandom, 16'($urandom)};
    {tw_cc, tw_ms, tw_ld} = 3'h7;
    nrst_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    {nrst_i, tw_ld} = 2'h2;
    for (int i = 0; i < 6; i++) begin
      {a_i, b_i} = {AW'($urandom), BW'($urandom)};
      issue({3'h0, 2'h0, X_MULT}, 4'h0, 1'b0, 3'h0, 3, 0, 0);
    end
    repeat (3) @(posedge ref_clk_i);
    #1;
    use_v = '0;
    $display("test pipelined products done");
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 5; j++) begin
        {a_i, b_i, c_i} = {AW'($urandom), BW'($urandom), $urandom, 16'($urandom)};
        issue(opms[i], alus[j], 1'($urandom), 3'((i + j) % 4), 1, 0, i == 2);
      end
    end
    for (int i = 0; i < 4; i++) begin
      {acin_sel_i, bcin_sel_i} = 2'(i);
      issue({Z_PCIN, 2'h0, X_MULT}, 4'h0, 1'b0, 3'h0, 1, 0, 0);
    end
    has_c_i = 1'b0;
    issue({Z_C, Y_C, X_AB}, 4'h0, 1'b0, 3'h0, 1, 0, 0);
    has_c_i = 1'b1;
    $display("test operations and cascades done");
    for (int t = 0; t < 7; t++) begin
      {a_i, b_i, c_i, mask_cfg_i} = {AW'($urandom), BW'($urandom), $urandom, 16'($urandom), 48'h0};
      rv = $signed({a_i, b_i});
      if (t != 6) mask_cfg_i = {$urandom, 16'($urandom)};
      {pat_from_c_i, mask_from_c_i} = {t == 2, t == 3};
      rnd_sel_i = t == 4 ? MAS_MASK_RND1 : t == 5 ? MAS_MASK_RND2 : MAS_MASK_CFG;
      pattern_cfg_i = (t[0] ? ~rv : rv) ^ PW'(t == 6);
      if (t == 2) c_i = rv;
      issue(XAB_OP, 4'h0, 1'b0, 3'h0, 1, 0, 0);
    end
    {pat_from_c_i, mask_from_c_i, pattern_cfg_i} = '0;
    rnd_sel_i = MAS_MASK_CFG;
    mask_cfg_i = 48'hFFFF_FFFF_FF00;
    foreach (ovs[i]) begin
      {a_i, b_i} = {25'h0, ovs[i]};
      issue(XAB_OP, 4'h0, 1'b0, 3'h0, 1, 0, 0);
    end
    mask_cfg_i = '1;
    $display("test pattern detector done");
    for (int s = 0; s < 3; s++) begin
      split_i = mas_split_t'(s);
      for (int i = 0; i < 3; i++) begin
        {a_i, b_i, c_i} = {AW'($urandom), BW'($urandom), $urandom, 16'($urandom)};
        issue({Z_C, 2'h0, X_AB}, 4'h0, 1'b0, 3'h0, 1, 0, 0);
      end
    end
    split_i = MAS_ONE48;
    // stage clear first: the match flag left high by the last test would clear p one op too early
    {rst_v[4], autoreset_i} = 2'h3;
    issue(XAB_OP, 4'h0, 1'b0, 3'h0, 1, 1, 0);
    rst_v[4] = 1'b0;
    issue(XAB_OP, 4'h0, 1'b0, 3'h0, 1, 0, 0);
    issue(XAB_OP, 4'h0, 1'b0, 3'h0, 1, 1, 0);
    autoreset_i = 1'b0;
    foreach (rows[i]) begin
      {rst_v[4], ce_v[4], grst_on_i, rst_i, gen_on_i, en_i} = rows[i][7:2];
      {a_i, b_i} = {AW'($urandom), BW'($urandom)};
      issue(XAB_OP, 4'h0, 1'b0, 3'h0, 1, int'(rows[i][1:0]), 0);
    end
    $display("test splits and resets done");
    for (int i = 0; i < 8 && notes.size() > 0; i++) @(negedge ref_clk_i);
    if (notes.size() > 0) err_total++;
    conclude();
  end
endmodule : mas_slice_tb
`default_nettype wire
